// ===== rtl/spm_perf_monitor.sv
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - count seconds holding any out-of-frame or frame alignment change
// - add each frame's section parity mismatches to section coding violations
// - section errored second: any section violation, out-of-frame or alignment change
// - section severe second: 16+ violations or out-of-frame, alignment change, signal loss
// - add each frame's line parity mismatches to line coding violations
// - line errored second: any line violation or line alarm indication
// - line severe second: 32+ line violations or line alarm indication
// - count path switches caused by signal fail or signal degrade
// - keep current interval plus four earlier interval slots, all readable
// - keep full tallies for current day and previous day
// - separate independent tally sets for primary and secondary link
module spm_perf_monitor #(
	parameter int CNT_W = 32,
	parameter int SEC_CYCLES = spm_pkg::SEC_CYCLES,
	parameter int INTERVAL_SECS = spm_pkg::INTERVAL_SECS,
	parameter int DAY_INTERVALS = spm_pkg::DAY_INTERVALS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [spm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [spm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire spm_pkg::spm_frame_s [spm_pkg::NLINK-1:0] frame_in,
	input wire logic active_secondary,
	input wire logic [spm_pkg::NLINK-1:0] signal_fail_flag,
	input wire logic [spm_pkg::NLINK-1:0] signal_degrade_flag
);

	localparam int SW = $clog2(SEC_CYCLES);

	function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] a,
			input logic [CNT_W-1:0] b);
		logic [CNT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
	endfunction

	logic [CNT_W-1:0] tally_r [spm_pkg::NLINK][spm_pkg::NBKT][spm_pkg::NCNT];
	logic [CNT_W-1:0] delta [spm_pkg::NLINK][spm_pkg::NCNT];

	logic en_r;
	logic force_r;
	logic [SW-1:0] cyc_r;
	logic [15:0] secs_r;
	logic [15:0] intv_r;
	logic act_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	// time base
	wire sec_tick = (cyc_r == SW'(SEC_CYCLES - 1));
	wire last_sec = (secs_r == 16'(INTERVAL_SECS - 1));
	wire intv_end = (sec_tick & last_sec) | force_r;
	wire day_end = intv_end & (intv_r == 16'(DAY_INTERVALS - 1));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_r <= '0;
			secs_r <= '0;
			intv_r <= '0;
		end else begin
			cyc_r <= (sec_tick | force_r) ? '0 : cyc_r + SW'(1);
			if (intv_end) begin
				secs_r <= '0;
			end else if (sec_tick) begin
				secs_r <= secs_r + 16'h0001;
			end
			if (day_end) begin
				intv_r <= '0;
			end else if (intv_end) begin
				intv_r <= intv_r + 16'h0001;
			end
		end
	end

	// protection switching: credit the link that was left
	wire switched = (active_secondary != act_r);
	wire sw_cause = signal_fail_flag[act_r] | signal_degrade_flag[act_r];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			act_r <= 1'b0;
		end else begin
			act_r <= active_secondary;
		end
	end

	genvar l, c;
	generate
		for (l = 0; l < spm_pkg::NLINK; l++) begin : g_link
			spm_pkg::spm_frame_s fr;
			logic [5:0] s_cv_r, l_cv_r;
			logic s_frm_r, s_los_r, l_ais_r;
			logic [3:0] sb;
			logic [4:0] lb;
			logic [6:0] s_sum, l_sum;
			logic [5:0] s_cv_now, l_cv_now;
			logic s_frm_now, s_los_now, l_ais_now, psc_ev;

			assign fr = en_r ? frame_in[l] : '0;
			assign sb = fr.valid ? fr.sec_bip : 4'h0;
			assign lb = fr.valid ? fr.line_bip : 5'h00;
			assign s_sum = {1'b0, s_cv_r} + {3'h0, sb};
			assign l_sum = {1'b0, l_cv_r} + {2'h0, lb};
			assign s_cv_now = s_sum[6] ? spm_pkg::SEC_CV_MAX : s_sum[5:0];
			assign l_cv_now = l_sum[6] ? spm_pkg::SEC_CV_MAX : l_sum[5:0];
			// current-cycle events are folded in so nothing is lost at the strobe
			assign s_frm_now = s_frm_r | fr.oof | fr.cofa;
			assign s_los_now = s_los_r | fr.los;
			assign l_ais_now = l_ais_r | fr.line_ais;
			assign psc_ev = en_r & switched & sw_cause & (act_r == 1'(l));

			assign delta[l][spm_pkg::C_SFRM] = CNT_W'(sec_tick & s_frm_now);
			assign delta[l][spm_pkg::C_SCV] = CNT_W'(sb);
			assign delta[l][spm_pkg::C_SES] =
				CNT_W'(sec_tick & ((s_cv_now != 6'h00) | s_frm_now));
			assign delta[l][spm_pkg::C_SSES] = CNT_W'(sec_tick &
				((s_cv_now >= spm_pkg::SCV_SES_MIN) | s_frm_now | s_los_now));
			assign delta[l][spm_pkg::C_LCV] = CNT_W'(lb);
			assign delta[l][spm_pkg::C_LES] =
				CNT_W'(sec_tick & ((l_cv_now != 6'h00) | l_ais_now));
			assign delta[l][spm_pkg::C_LSES] = CNT_W'(sec_tick &
				((l_cv_now >= spm_pkg::LCV_SES_MIN) | l_ais_now));
			assign delta[l][spm_pkg::C_PSW] = CNT_W'(psc_ev);

			// per-second condition flags
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					s_cv_r <= '0;
					l_cv_r <= '0;
					s_frm_r <= 1'b0;
					s_los_r <= 1'b0;
					l_ais_r <= 1'b0;
				end else if (sec_tick) begin
					s_cv_r <= '0;
					l_cv_r <= '0;
					s_frm_r <= 1'b0;
					s_los_r <= 1'b0;
					l_ais_r <= 1'b0;
				end else begin
					s_cv_r <= s_cv_now;
					l_cv_r <= l_cv_now;
					s_frm_r <= s_frm_now;
					s_los_r <= s_los_now;
					l_ais_r <= l_ais_now;
				end
			end

			for (c = 0; c < spm_pkg::NCNT; c++) begin : g_cnt
				wire [CNT_W-1:0] cur_upd = sat_add(tally_r[l][spm_pkg::B_CUR][c], delta[l][c]);
				wire [CNT_W-1:0] day_upd = sat_add(tally_r[l][spm_pkg::B_TODAY][c], delta[l][c]);

				always_ff @(posedge sys_clk or negedge nrst) begin
					if (!nrst) begin
						for (int b = 0; b < spm_pkg::NBKT; b++) begin
							tally_r[l][b][c] <= '0;
						end
					end else begin
						if (intv_end) begin
							tally_r[l][spm_pkg::B_CUR][c] <= '0;
							tally_r[l][spm_pkg::B_HIST0][c] <= cur_upd;
							for (int h = 1; h < spm_pkg::NHIST; h++) begin
								tally_r[l][int'(spm_pkg::B_HIST0) + h][c] <=
									tally_r[l][int'(spm_pkg::B_HIST0) + h - 1][c];
							end
						end else begin
							tally_r[l][spm_pkg::B_CUR][c] <= cur_upd;
						end
						if (day_end) begin
							tally_r[l][spm_pkg::B_TODAY][c] <= '0;
							tally_r[l][spm_pkg::B_YEST][c] <= day_upd;
						end else begin
							tally_r[l][spm_pkg::B_TODAY][c] <= day_upd;
						end
					end
				end
			end
		end
	endgenerate

	// write channel: address and data taken together
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	wire wr_ctrl = (s_axi_awaddr == spm_pkg::A_CTRL);
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_r <= spm_pkg::CTRL_EN_RST;
			force_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= spm_pkg::RESP_OKAY;
		end else begin
			force_r <= wr_go & wr_ctrl & s_axi_wstrb[0] & s_axi_wdata[spm_pkg::CTRL_FORCE_BIT];
			if (wr_go & wr_ctrl & s_axi_wstrb[0]) begin
				en_r <= s_axi_wdata[spm_pkg::CTRL_EN_BIT];
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ctrl ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// read decode: tallies addressed by link, bucket, tally
	wire rd_go = s_axi_arvalid & ~rvalid_r;
	wire rd_link = s_axi_araddr[spm_pkg::A_LINK_BIT];
	wire [2:0] rd_bkt = s_axi_araddr[spm_pkg::A_BKT_LSB +: 3];
	wire [2:0] rd_cnt = s_axi_araddr[spm_pkg::A_CNT_LSB +: 3];
	wire rd_tally = ~s_axi_araddr[spm_pkg::A_REG_BIT] & (rd_bkt < 3'(spm_pkg::NBKT)) &
		(s_axi_araddr[1:0] == 2'h0);
	wire rd_ctrl = (s_axi_araddr == spm_pkg::A_CTRL);
	wire rd_stat = (s_axi_araddr == spm_pkg::A_STAT);
	wire [CNT_W-1:0] tally_word = rd_tally ? tally_r[rd_link][rd_bkt][rd_cnt] : '0;
	wire [31:0] ctrl_word = {30'h0, 1'b0, en_r};
	wire [31:0] stat_word = {intv_r, secs_r};
	wire [31:0] rd_word = rd_tally ? 32'(tally_word) :
		rd_ctrl ? ctrl_word : rd_stat ? stat_word : 32'h0;
	wire rd_ok = rd_tally | rd_ctrl | rd_stat;
	assign s_axi_arready = ~rvalid_r;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_r <= 1'b0;
			rresp_r <= spm_pkg::RESP_OKAY;
			rdata_r <= '0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_ok ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
			rdata_r <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

endmodule

`default_nettype wire

// ===== rtl/spm_pkg.sv
package spm_pkg;

	localparam int NLINK = 2;
	localparam int NHIST = 4;
	localparam int NBKT = 7;
	localparam int NCNT = 8;

	// bucket indices
	localparam logic [2:0] B_CUR = 3'h0;
	localparam logic [2:0] B_HIST0 = 3'h1;
	localparam logic [2:0] B_TODAY = 3'h5;
	localparam logic [2:0] B_YEST = 3'h6;

	// tally indices within a bucket
	localparam int C_SFRM = 0;
	localparam int C_SCV = 1;
	localparam int C_SES = 2;
	localparam int C_SSES = 3;
	localparam int C_LCV = 4;
	localparam int C_LES = 5;
	localparam int C_LSES = 6;
	localparam int C_PSW = 7;

	// per-second thresholds
	localparam logic [5:0] SCV_SES_MIN = 6'h10;
	localparam logic [5:0] LCV_SES_MIN = 6'h20;
	localparam logic [5:0] SEC_CV_MAX = 6'h3f;

	// timing
	localparam int ONE_SEC_S = 1;
	localparam int CLK_HZ = 100_000_000;
	localparam int SEC_CYCLES = ONE_SEC_S * CLK_HZ;
	localparam int INTERVAL_SECS = 900;
	localparam int DAY_INTERVALS = 96;

	// register map
	localparam int ADDR_W = 10;
	localparam logic [9:0] A_CTRL = 10'h200;
	localparam logic [9:0] A_STAT = 10'h204;
	localparam int A_REG_BIT = 9;
	localparam int A_LINK_BIT = 8;
	localparam int A_BKT_LSB = 5;
	localparam int A_CNT_LSB = 2;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FORCE_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-frame indications from the framer of one link
	typedef struct packed {
		logic valid;
		logic oof;
		logic cofa;
		logic los;
		logic [3:0] sec_bip;
		logic [4:0] line_bip;
		logic line_ais;
	} spm_frame_s;

endpackage

// ===== testbench/spm_perf_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module spm_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [spm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [spm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wans; s_wtake |=> s_axi_bvalid; endproperty
	a_wans: assert property (p_wans) else $error("write response late");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response not held");
	property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdrop: assert property (p_bdrop) else $error("write response not released");
	property p_wbad; s_wtake and s_axi_awaddr != spm_pkg::A_CTRL |=> s_axi_bresp == 2'h2; endproperty
	a_wbad: assert property (p_wbad) else $error("stray write not refused");
	property p_rans; s_rtake |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rans: assert property (p_rans) else $error("read data late");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_rdrop: assert property (p_rdrop) else $error("read data not released");
	property p_bkt7;
		s_rtake and !s_axi_araddr[9] && s_axi_araddr[7:5] == 3'h7 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_bkt7: assert property (p_bkt7) else $error("unused bucket not refused");
endmodule
bind spm_perf_monitor spm_props spm_props_inst (.*);
`default_nettype wire

// ===== testbench/spm_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module spm_framer_model (
	input wire logic sys_clk,
	input wire logic send,
	input wire logic lnk,
	input wire logic [3:0] sbip,
	input wire logic [4:0] lbip,
	input wire logic alarm,
	output var spm_pkg::spm_frame_s [spm_pkg::NLINK-1:0] frame_in
);
	initial frame_in = '0;
	// counts outside a frame carry no meaning, so they keep changing
	always @(posedge sys_clk) begin
		for (int i = 0; i < spm_pkg::NLINK; i++) begin
			frame_in[i].valid <= send && lnk == i;
			frame_in[i].sec_bip <= (send && lnk == i) ? sbip : ~frame_in[i].sec_bip;
			frame_in[i].line_bip <= (send && lnk == i) ? lbip : ~frame_in[i].line_bip;
			frame_in[i].oof <= alarm && i == 0;
			frame_in[i].line_ais <= alarm && i == 0;
			frame_in[i].cofa <= 1'b0;
			frame_in[i].los <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [1:0] OK = spm_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = spm_pkg::RESP_SLVERR;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [9:0] s_axi_awaddr = 10'h0;
	logic [9:0] s_axi_araddr = 10'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, v;
	spm_pkg::spm_frame_s [1:0] frame_in;
	logic active_secondary = 1'b0;
	logic [1:0] signal_fail_flag = 2'h0;
	logic [1:0] signal_degrade_flag = 2'h0;
	logic send = 1'b0;
	logic lnk = 1'b0;
	logic alarm = 1'b0;
	logic [3:0] sbip = 4'h0;
	logic [4:0] lbip = 5'h0;
	int err_total = 0;
	int n_compared = 0;
	int seed = 65;
	int s0, s1, scv, lcv;
	int exp_t[8];
	always #5 sys_clk = ~sys_clk;
	spm_perf_monitor #(.SEC_CYCLES(20), .INTERVAL_SECS(8), .DAY_INTERVALS(50)) spm_perf_monitor_inst (.*);
	spm_framer_model spm_framer_model_inst (.*);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(posedge sys_clk);
		while (!s_axi_awready) @(posedge sys_clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge sys_clk);
		while (!s_axi_bvalid) @(posedge sys_clk);
		s_axi_bready <= 1'b1;
		@(posedge sys_clk);
		check(32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(posedge sys_clk);
		while (!s_axi_arready) @(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		@(posedge sys_clk);
		while (!s_axi_rvalid) @(posedge sys_clk);
		s_axi_rready <= 1'b1;
		@(posedge sys_clk);
		check(s_axi_rdata, ed);
		check(32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'b0;
	endtask
	// caller lowers send after the last frame
	task automatic frm(input logic l, input logic [3:0] s, input logic [4:0] n);
		send <= 1'b1;
		lnk <= l;
		sbip <= s;
		lbip <= n;
		@(posedge sys_clk);
	endtask
	function automatic int sev(input int cv, input int min, input logic al);
		return (cv >= min || al) ? 1 : 0;
	endfunction
	function automatic logic [9:0] ta(input int l, input int b, input int t);
		return 10'(l * 256 + b * 32 + t * 4);
	endfunction
	task automatic tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(spm_pkg::A_CTRL, 32'h1, OK);
		wr(spm_pkg::A_CTRL, 32'h0, 4'he, OK);
		rd(spm_pkg::A_CTRL, 32'h1, OK);
		wr(10'h300, 32'h0, 4'hf, ERR);
		for (int a = 0; a < 512; a += 4) begin
			rd(10'(a), 32'h0, (a[7:5] == 3'h7) ? ERR : OK);
		end
		// threshold hit, one short of it, then alarms with counts short
		for (int k = 0; k < 3; k++) begin
			wr(spm_pkg::A_CTRL, 32'h3, 4'hf, OK);
			alarm <= (k == 2);
			frm(1'b0, 4'hf, 5'h1f);
			frm(1'b0, 4'(k == 0), 5'(k == 0));
			send <= 1'b0;
			repeat (25) @(posedge sys_clk);
			alarm <= 1'b0;
			wr(spm_pkg::A_CTRL, 32'h3, 4'hf, OK);
			scv = 15 + int'(k == 0);
			lcv = 31 + int'(k == 0);
			exp_t = '{int'(k == 2), scv, 1, sev(scv, 16, k == 2), lcv, 1, sev(lcv, 32, k == 2), 0};
			for (int t = 0; t < 8; t++) begin
				rd(ta(0, 1, t), exp_t[t], OK);
			end
			rd(ta(0, 0, 1), 32'h0, OK);
		end
		s0 = 0;
		s1 = 0;
		repeat (6) begin
			v = $random(seed);
			frm(1'b1, v[3:0], v[8:4]);
			s0 += v[3:0];
			s1 += v[8:4];
		end
		send <= 1'b0;
		signal_fail_flag <= 2'h1;
		@(posedge sys_clk);
		active_secondary <= 1'b1;
		@(posedge sys_clk);
		signal_fail_flag <= 2'h0;
		signal_degrade_flag <= 2'h2;
		@(posedge sys_clk);
		active_secondary <= 1'b0;
		@(posedge sys_clk);
		signal_degrade_flag <= 2'h0;
		@(posedge sys_clk);
		active_secondary <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(ta(1, 0, 1), 32'(s0), OK);
		rd(ta(1, 0, 4), 32'(s1), OK);
		rd(ta(1, 5, 1), 32'(s0), OK);
		rd(ta(0, 0, 4), 32'h0, OK);
		rd(ta(0, 0, 7), 32'h1, OK);
		rd(ta(1, 0, 7), 32'h1, OK);
		tally_and_finish;
	end
endmodule
`default_nettype wire
